// ===== src/pfcu_top.sv
// Operation
// - Indirect call: decrement index, push incremented counter, jump to jump address register.
// - Direct call: decrement index, push incremented counter, jump to immediate.
// - Return: counter from stack entry at index, then increment index.
// - Return-and-skip: return, then the next instruction acts as no-operation.
// - Interrupt return: restore counter, context, bank and status word, increment index.
// - Interrupt-on instruction sets the global interrupt enable.
// - No interrupt accepted until the instruction after interrupt-on completes.
// - Accept at instruction boundary, never right after a flow change; jump to vector.
// - Disabled source only pends; it is taken once its enable is set.
// - Interrupt-off instruction clears the global interrupt enable.
// - Stop instruction halts the clock; operand selects the release condition.
// - Halt instruction enters reduced power; operand selects the release condition.
// - No-operation only advances the counter and takes one cycle.
// - Jump address register width is a build parameter, 10 or 11 bits.
// - Indirect branch loads the counter from the register, stack untouched.
// - Jump address register has four nibbles; the top one is read-only.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pfcu_top #(
  parameter int AR_W = 11,
  parameter int PC_W = 11,
  parameter int IDX_W = 3,
  parameter int STACK_DEPTH = 5,
  parameter int NSRC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [NSRC-1:0] irq_req,
  input wire logic release_pin,
  output logic [PC_W-1:0] pc,
  output logic sysclk_run,
  output logic halt_mode,
  output logic stop_mode,
  output logic irq_out
);

  localparam logic [IDX_W-1:0] IDX_RST = IDX_W'(STACK_DEPTH);
  localparam int STAT_W_L = pfcu_pkg::STAT_W;
  // Architectural state.
  logic [11:0] jaddr;
  logic [IDX_W-1:0] stack_index;
  logic global_irq_enable, skip_next, irq_hold;
  logic [NSRC-1:0] source_irq_enable, source_irq_pending;
  logic [7:0] interrupt_context_register;
  logic [PC_W-1:0] return_address_stack [2**IDX_W];
  logic [7:0] interrupt_context_stack [2**IDX_W];
  logic [3:0] release_cond;
  pfcu_pkg::pfcu_power_t power_state;
  logic [STAT_W_L-1:0] status, mask;
  // Bus data-phase bookkeeping.
  logic wr_pend, rd_status;
  logic [7:0] wr_addr;
  // Release pin synchroniser.
  logic rel_meta, rel_sync;
  // Decode results.
  logic [4:0] op5;
  logic [6:0] key;
  logic [IDX_W-1:0] dec_idx;
  logic [PC_W-1:0] pc_inc, ar_target, vector, next_pc, push_pc;
  logic [NSRC-1:0] ready_src, taken_src;
  logic low_zero, take_irq, exec, do_push, do_pop, set_ge, clr_ge, set_skip, ctx_restore;
  logic enter_stop, enter_halt, flow_change, is_ei, addr_phase;
  logic [STAT_W_L-1:0] ev, next_status;
  logic [31:0] rd_mux;

  assign op5 = instr_word[15:11];
  assign key = instr_word[10:4];
  assign low_zero = (instr_word[3:0] == 4'h0);
  assign pc_inc = PC_W'(pc + 1'b1);
  // Only the configured low bits steer a jump; the rest are dropped.
  assign ar_target = PC_W'(jaddr[AR_W-1:0]);
  assign dec_idx = IDX_W'(stack_index - 1'b1);
  // A pending source becomes ready the moment software enables it, so no request is lost meanwhile.
  assign ready_src = source_irq_pending & source_irq_enable;
  // Acceptance waits one instruction after interrupt-on or a flow change, and never cuts into a skip slot.
  assign take_irq = (power_state == pfcu_pkg::PFCU_RUN) && instr_valid && !skip_next &&
                    global_irq_enable && !irq_hold && (|ready_src);
  assign exec = (power_state == pfcu_pkg::PFCU_RUN) && instr_valid && !take_irq;
  // Lowest numbered ready source wins and picks its vector.
  always_comb begin
    taken_src = '0;
    vector = PC_W'(pfcu_pkg::VEC_BASE);
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (ready_src[i]) begin
        taken_src = NSRC'(1'b1) << i;
        vector = PC_W'(pfcu_pkg::VEC_BASE + 11'(i));
      end
    end
  end
  // Instruction decode and program-counter steering.
  always_comb begin
    next_pc = pc;
    push_pc = pc;
    {do_push, do_pop, set_ge, clr_ge, set_skip, ctx_restore} = 6'h00;
    {enter_stop, enter_halt, flow_change, is_ei} = 4'h0;
    if (take_irq) begin
      // The presented instruction is not executed; its address is the return point.
      do_push = 1'b1;
      push_pc = pc;
      next_pc = vector;
      clr_ge = 1'b1;
    end else if (exec) begin
      next_pc = pc_inc;
      if (!skip_next) begin
        if (op5 == pfcu_pkg::OP_BR) begin
          next_pc = instr_word[PC_W-1:0];
          flow_change = 1'b1;
        end else if (op5 == pfcu_pkg::OP_CALL) begin
          do_push = 1'b1;
          push_pc = pc_inc;
          next_pc = instr_word[PC_W-1:0];
          flow_change = 1'b1;
        end else if (op5 == pfcu_pkg::OP_GROUP) begin
          case (key)
            pfcu_pkg::KEY_STOP: enter_stop = 1'b1;
            pfcu_pkg::KEY_HALT: enter_halt = 1'b1;
            pfcu_pkg::KEY_BR_AR: begin
              if (low_zero) begin
                next_pc = ar_target;
                flow_change = 1'b1;
              end
            end
            pfcu_pkg::KEY_CALL_AR: begin
              if (low_zero) begin
                do_push = 1'b1;
                push_pc = pc_inc;
                next_pc = ar_target;
                flow_change = 1'b1;
              end
            end
            pfcu_pkg::KEY_RET, pfcu_pkg::KEY_RETURN_AND_SKIP, pfcu_pkg::KEY_RETURN_FROM_IRQ: begin
              if (low_zero) begin
                do_pop = 1'b1;
                next_pc = return_address_stack[stack_index];
                flow_change = 1'b1;
                set_skip = (key == pfcu_pkg::KEY_RETURN_AND_SKIP);
                ctx_restore = (key == pfcu_pkg::KEY_RETURN_FROM_IRQ);
              end
            end
            pfcu_pkg::KEY_EI: begin
              set_ge = low_zero;
              is_ei = low_zero;
            end
            pfcu_pkg::KEY_DI: clr_ge = low_zero;
            default: next_pc = pc_inc;
          endcase
        end
      end
    end
  end

  // Program counter.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= '0;
    end else begin
      pc <= next_pc;
    end
  end

  // Both stacks share the index and need no reset, since an entry is written before it is read back.
  always_ff @(posedge hclk) begin
    if (do_push) begin
      return_address_stack[dec_idx] <= push_pc;
      interrupt_context_stack[dec_idx] <= interrupt_context_register;
    end
  end

  // Stack index: instruction updates win over a software write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_index <= IDX_RST;
    end else if (do_push) begin
      stack_index <= dec_idx;
    end else if (do_pop) begin
      stack_index <= IDX_W'(stack_index + 1'b1);
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_STACK_IDX) begin
      stack_index <= hwdata[IDX_W-1:0];
    end
  end

  // Context register holds bank in the high nibble and status word in the low one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_context_register <= pfcu_pkg::CONTEXT_RST;
    end else if (ctx_restore) begin
      interrupt_context_register <= interrupt_context_stack[stack_index];
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_CONTEXT) begin
      interrupt_context_register <= hwdata[7:0];
    end
  end

  // Jump address register: only the three low nibbles are writable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jaddr <= pfcu_pkg::JADDR_RST;
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_JADDR) begin
      jaddr <= hwdata[pfcu_pkg::JADDR_RO_LSB-1:0];
    end
  end

  // Global enable: instruction effects override a software write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_irq_enable <= 1'b0;
    end else if (set_ge) begin
      global_irq_enable <= 1'b1;
    end else if (clr_ge) begin
      global_irq_enable <= 1'b0;
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_IRQ_CTRL) begin
      global_irq_enable <= hwdata[0];
    end
  end

  // Holdoff is set by interrupt-on, a flow change or an acceptance; the next executed instruction clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_hold <= 1'b0;
    end else if (is_ei || flow_change || take_irq) begin
      irq_hold <= 1'b1;
    end else if (exec) begin
      irq_hold <= 1'b0;
    end
  end

  // Skip flag consumes exactly one instruction slot as a no-operation.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_next <= 1'b0;
    end else if (set_skip) begin
      skip_next <= 1'b1;
    end else if (exec) begin
      skip_next <= 1'b0;
    end
  end
  // Per-source enables are software owned.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_irq_enable <= '0;
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_SRC_EN) begin
      source_irq_enable <= hwdata[NSRC-1:0];
    end
  end

  // Only a real acceptance or a write-one clears a flag, and a request in that cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_irq_pending <= '0;
    end else begin
      source_irq_pending <= (source_irq_pending & ~(take_irq ? taken_src : '0) &
                             ~((wr_pend && wr_addr == pfcu_pkg::OFF_SRC_PEND) ? hwdata[NSRC-1:0] : '0))
                            | irq_req;
    end
  end

  // Release pin passes two flip-flops before anything looks at it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rel_meta <= 1'b0;
      rel_sync <= 1'b0;
    end else begin
      rel_meta <= release_pin;
      rel_sync <= rel_meta;
    end
  end

  // Power state; condition decoding lives outside, it only raises the release pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_state <= pfcu_pkg::PFCU_RUN;
      release_cond <= 4'h0;
      sysclk_run <= 1'b1;
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
    end else if (enter_stop) begin
      power_state <= pfcu_pkg::PFCU_STOP;
      release_cond <= instr_word[3:0];
      sysclk_run <= 1'b0;
      stop_mode <= 1'b1;
    end else if (enter_halt) begin
      power_state <= pfcu_pkg::PFCU_HALT;
      release_cond <= instr_word[3:0];
      halt_mode <= 1'b1;
    end else if (rel_sync && power_state != pfcu_pkg::PFCU_RUN) begin
      power_state <= pfcu_pkg::PFCU_RUN;
      sysclk_run <= 1'b1;
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
    end
  end

  // Sticky events; a read of the status register clears, a new event wins.
  assign ev = STAT_W_L'({enter_halt, enter_stop, take_irq});
  assign next_status = (status & ~(rd_status ? '1 : '0)) | ev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
      irq_out <= 1'b0;
    end else begin
      status <= next_status;
      irq_out <= |(next_status & mask);
    end
  end
  // Mask shares the status layout; only unmasked events raise the interrupt line.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= '0;
    end else if (wr_pend && wr_addr == pfcu_pkg::OFF_MASK) begin
      mask <= hwdata[STAT_W_L-1:0];
    end
  end

  // Bus slave: zero wait states, always OKAY, read data latched at the address phase.
  assign addr_phase = hsel && htrans[1] && hready;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      pfcu_pkg::OFF_JADDR: rd_mux = 32'(pfcu_pkg::JADDR_TOP_NIBBLE) | 32'(jaddr);
      pfcu_pkg::OFF_STACK_IDX: rd_mux = 32'(stack_index);
      pfcu_pkg::OFF_IRQ_CTRL: rd_mux = 32'(global_irq_enable);
      pfcu_pkg::OFF_SRC_EN: rd_mux = 32'(source_irq_enable);
      pfcu_pkg::OFF_SRC_PEND: rd_mux = 32'(source_irq_pending);
      pfcu_pkg::OFF_CONTEXT: rd_mux = 32'(interrupt_context_register);
      pfcu_pkg::OFF_PC: rd_mux = 32'(pc);
      pfcu_pkg::OFF_POWER: rd_mux = 32'({stop_mode, halt_mode, release_cond});
      pfcu_pkg::OFF_STATUS: rd_mux = 32'(status);
      pfcu_pkg::OFF_MASK: rd_mux = 32'(mask);
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_status <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
      wr_addr <= haddr[7:0];
      rd_status <= addr_phase && !hwrite && (haddr == 32'(pfcu_pkg::OFF_STATUS));
      hrdata <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : pfcu_top
`default_nettype wire

// ===== src/pfcu_pkg.sv
package pfcu_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_JADDR = 8'h00;
  localparam logic [7:0] OFF_STACK_IDX = 8'h04;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h08;
  localparam logic [7:0] OFF_SRC_EN = 8'h0C;
  localparam logic [7:0] OFF_SRC_PEND = 8'h10;
  localparam logic [7:0] OFF_CONTEXT = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;
  localparam logic [7:0] OFF_POWER = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;

  // Field positions.
  localparam int JADDR_RO_LSB = 12;
  localparam int STAT_IRQ_TAKEN = 0;
  localparam int STAT_STOP = 1;
  localparam int STAT_HALT = 2;
  localparam int STAT_W = 3;
  localparam int POWER_HALT_BIT = 4;
  localparam int POWER_STOP_BIT = 5;

  // Values after reset.
  localparam logic [11:0] JADDR_RST = 12'h000;
  localparam logic [7:0] CONTEXT_RST = 8'h00;
  localparam logic [15:0] JADDR_TOP_NIBBLE = 16'h0000;

  // Instruction fields: op5 at [15:11], f3 at [10:8], f4 at [7:4], low nibble at [3:0].
  localparam logic [4:0] OP_GROUP = 5'h07;
  localparam logic [4:0] OP_BR = 5'h0C;
  localparam logic [4:0] OP_CALL = 5'h1C;
  localparam logic [6:0] KEY_BR_AR = 7'h04;
  localparam logic [6:0] KEY_CALL_AR = 7'h05;
  localparam logic [6:0] KEY_RET = 7'h0E;
  localparam logic [6:0] KEY_RETURN_AND_SKIP = 7'h1E;
  localparam logic [6:0] KEY_RETURN_FROM_IRQ = 7'h4E;
  localparam logic [6:0] KEY_EI = 7'h0F;
  localparam logic [6:0] KEY_DI = 7'h1F;
  localparam logic [6:0] KEY_STOP = 7'h2F;
  localparam logic [6:0] KEY_HALT = 7'h3F;
  localparam logic [6:0] KEY_NOP = 7'h4F;

  // First interrupt vector; source i jumps to base plus i.
  localparam logic [10:0] VEC_BASE = 11'h001;

  // Power state, Gray coded along run, halt, stop.
  typedef enum logic [1:0] {
    PFCU_RUN = 2'b00,
    PFCU_HALT = 2'b01,
    PFCU_STOP = 2'b11
  } pfcu_power_t;

endpackage : pfcu_pkg

// ===== verification/pfcu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pfcu_monitor #(
  parameter int PC_W = 11,
  parameter int NSRC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [PC_W-1:0] pc,
  input wire logic sysclk_run,
  input wire logic halt_mode,
  input wire logic stop_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic run;
  logic vec;
  logic skip_slot;
  // An accepted interrupt replaces the presented instruction, so flow checks also allow a vector target.
  assign run = !halt_mode && !stop_mode;
  assign vec = pc >= PC_W'(1) && pc <= PC_W'(NSRC);
  // The slot after a return-and-skip acts as a no-operation, so decode checks stand aside there.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_slot <= 1'b0;
    end else if (instr_valid && run) begin
      skip_slot <= (instr_word == 16'h39E0) && !skip_slot;
    end
  end
  sequence s_take(logic [15:0] k);
    instr_valid && run && instr_word == k;
  endsequence
  sequence s_gap_then_next;
    !instr_valid ##1 instr_valid;
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  property p_rd_idle;
    !(hsel && htrans[1] && !hwrite && hready) |=> hrdata == 32'h0000_0000;
  endproperty
  property p_nop;
    s_take(16'h3CF0) |=> pc == $past(pc) + 1'b1 || vec;
  endproperty
  property p_call_imm;
    !skip_slot && instr_valid && run && instr_word[15:11] == pfcu_pkg::OP_CALL |=>
      pc == $past(instr_word[PC_W-1:0]) || vec;
  endproperty
  property p_stop;
    !skip_slot && instr_valid && run && instr_word[15:4] == 12'h3AF |=> (stop_mode && !sysclk_run) || vec;
  endproperty
  property p_halt;
    !skip_slot && instr_valid && run && instr_word[15:4] == 12'h3BF |=> halt_mode || vec;
  endproperty
  property p_frozen;
    (halt_mode || stop_mode) ##1 (halt_mode || stop_mode) |-> $stable(pc);
  endproperty
  property p_clk_off;
    stop_mode |-> !sysclk_run;
  endproperty
  property p_skip;
    !skip_slot ##0 s_take(16'h39E0) ##1 s_gap_then_next |=> pc == $past(pc) + 1'b1;
  endproperty
  property p_ei_holdoff;
    !skip_slot ##0 s_take(16'h38F0) ##1 !instr_valid ##1 s_take(16'h3CF0) |=> pc == $past(pc) + 1'b1;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a data phase");
  a_nop: assert property (p_nop) else $error("no-operation did not advance the counter by one");
  a_call_imm: assert property (p_call_imm) else $error("direct call went to a wrong target");
  a_stop: assert property (p_stop) else $error("stop instruction did not stop the clock");
  a_halt: assert property (p_halt) else $error("halt instruction did not enter halt");
  a_frozen: assert property (p_frozen) else $error("counter moved in a low-power state");
  a_clk_off: assert property (p_clk_off) else $error("clock runs in stop state");
  a_skip: assert property (p_skip) else $error("skipped slot did not take one step");
  a_ei_holdoff: assert property (p_ei_holdoff) else $error("interrupt taken right after enable");
endmodule : pfcu_monitor
`default_nettype wire

// ===== verification/pfcu_irq_src.sv
`timescale 1ns/1ps
`default_nettype none
module pfcu_irq_src #(
  parameter int NSRC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NSRC-1:0] fire,
  input wire logic wake,
  output logic [NSRC-1:0] irq_req,
  output logic release_pin
);
  logic [1:0] hold;
  // Requests are single-cycle pulses, so the core must latch them as pending itself.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= fire;
    end
  end
  // The wake line stays high a few cycles so that the two-stage synchroniser surely sees it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold <= 2'd0;
      release_pin <= 1'b0;
    end else begin
      hold <= wake ? 2'd3 : (hold != 2'd0 ? hold - 2'd1 : 2'd0);
      release_pin <= wake || hold != 2'd0;
    end
  end
endmodule : pfcu_irq_src
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int AR_W = 10;
  localparam int PC_W = 11;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = '0;
  logic [3:0] fire = '0;
  logic wake = 1'b0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic sysclk_run;
  logic halt_mode;
  logic stop_mode;
  logic irq_out;
  logic release_pin;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [3:0] irq_req;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] pc0;
  int err_total = 0;
  int compares = 0;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  pfcu_top #(.AR_W(AR_W), .PC_W(PC_W)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid), .instr_word(instr_word), .irq_req(irq_req),
    .release_pin(release_pin), .pc(pc), .sysclk_run(sysclk_run), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .irq_out(irq_out));
  pfcu_irq_src #(.NSRC(4)) src (.hclk(hclk), .hresetn(hresetn), .fire(fire), .wake(wake), .irq_req(irq_req),
    .release_pin(release_pin));

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  // Waits for ready under a bound, since a stuck slave would otherwise hang the run.
  task automatic wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask : wt

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wt;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0000_0000);
    chk_word(rd, exp, what);
  endtask : rdchk

  // One instruction, then one idle cycle so the counter is settled when read.
  task automatic exec(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge hclk);
    instr_valid <= 1'b0;
    @(posedge hclk);
  endtask : exec

  task automatic pcchk(input logic [31:0] exp, input string what);
    chk_word(32'(pc), exp, what);
  endtask : pcchk

  task automatic pulse(input logic [3:0] s);
    fire <= s;
    @(posedge hclk);
    fire <= 4'h0;
    @(posedge hclk);
  endtask : pulse

  task automatic wakeup;
    int n;
    n = 0;
    wake <= 1'b1;
    @(posedge hclk);
    wake <= 1'b0;
    while ((halt_mode | stop_mode | release_pin) !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask : wakeup

  task automatic t_reset;
    rdchk(pfcu_pkg::OFF_STACK_IDX, 32'h0000_0005, "index");
    bus(8'h40, 1'b1, 32'h0000_FFFF);
    rdchk(8'h40, 32'h0000_0000, "unmapped");
    chk_word(32'({halt_mode, stop_mode, irq_out, sysclk_run}), 32'h0000_0001, "modes");
    pcchk(32'h0000_0000, "pc");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_jaddr;
    bus(pfcu_pkg::OFF_JADDR, 1'b1, 32'h0000_FFFF);
    rdchk(pfcu_pkg::OFF_JADDR, 32'h0000_0FFF, "jaddr");
    exec(16'h3840);
    pcchk(32'h0000_03FF, "br");
    rdchk(pfcu_pkg::OFF_STACK_IDX, 32'h0000_0005, "index");
    $display("t_jaddr done");
  endtask : t_jaddr

  task automatic t_call;
    bus(pfcu_pkg::OFF_JADDR, 1'b1, 32'h0000_0020);
    pc0 = pc;
    exec(16'h3850);
    pcchk(32'h0000_0020, "call");
    rdchk(pfcu_pkg::OFF_STACK_IDX, 32'h0000_0004, "index");
    exec(16'h38E0);
    pcchk(32'(pc0) + 1, "ret");
    rdchk(pfcu_pkg::OFF_STACK_IDX, 32'h0000_0005, "index");
    pc0 = pc;
    exec(16'hE155);
    pcchk(32'h0000_0155, "call imm");
    exec(16'h39E0);
    pcchk(32'(pc0) + 1, "return_and_skip");
    exec(16'h6300);
    pcchk(32'(pc0) + 2, "skip");
    exec(16'h6123);
    pcchk(32'h0000_0123, "br imm");
    $display("t_call done");
  endtask : t_call

  task automatic t_irq;
    bus(pfcu_pkg::OFF_MASK, 1'b1, 32'h0000_0001);
    bus(pfcu_pkg::OFF_CONTEXT, 1'b1, 32'h0000_00A5);
    exec(16'h38F0);
    exec(16'h39F0);
    rdchk(pfcu_pkg::OFF_IRQ_CTRL, 32'h0000_0000, "di");
    pulse(4'h4);
    rdchk(pfcu_pkg::OFF_SRC_PEND, 32'h0000_0004, "pend");
    exec(16'h38F0);
    rdchk(pfcu_pkg::OFF_IRQ_CTRL, 32'h0000_0001, "ei");
    pc0 = pc;
    exec(16'h3CF0);
    exec(16'h3CF0);
    pcchk(32'(pc0) + 2, "masked src");
    bus(pfcu_pkg::OFF_SRC_EN, 1'b1, 32'h0000_0004);
    exec(16'h3CF0);
    pcchk(32'h0000_0003, "vector");
    chk_word(32'(irq_out), 32'h0000_0001, "irq");
    rdchk(pfcu_pkg::OFF_STATUS, 32'h0000_0001, "status");
    rdchk(pfcu_pkg::OFF_SRC_PEND, 32'h0000_0000, "pend");
    chk_word(32'(irq_out), 32'h0000_0000, "irq");
    bus(pfcu_pkg::OFF_CONTEXT, 1'b1, 32'h0000_0000);
    exec(16'h3CE0);
    pcchk(32'(pc0) + 2, "return_from_irq");
    rdchk(pfcu_pkg::OFF_CONTEXT, 32'h0000_00A5, "context");
    rdchk(pfcu_pkg::OFF_STACK_IDX, 32'h0000_0005, "index");
    pulse(4'h4);
    exec(16'h38F0);
    pc0 = pc;
    exec(16'h3CF0);
    pcchk(32'(pc0) + 1, "holdoff");
    exec(16'h3CF0);
    pcchk(32'h0000_0003, "vector");
    exec(16'h3CE0);
    pcchk(32'(pc0) + 1, "return_from_irq");
    pulse(4'h2);
    rdchk(pfcu_pkg::OFF_SRC_PEND, 32'h0000_0002, "pend masked");
    bus(pfcu_pkg::OFF_SRC_PEND, 1'b1, 32'h0000_0002);
    rdchk(pfcu_pkg::OFF_SRC_PEND, 32'h0000_0000, "pend clear");
    $display("t_irq done");
  endtask : t_irq

  task automatic t_power;
    exec(16'h3BF5);
    chk_word(32'(halt_mode), 32'h0000_0001, "halt");
    rdchk(pfcu_pkg::OFF_POWER, 32'h0000_0015, "power");
    pc0 = pc;
    exec(16'h3CF0);
    pcchk(32'(pc0), "halt ignore");
    wakeup;
    exec(16'h3AF3);
    chk_word(32'({stop_mode, sysclk_run}), 32'h0000_0002, "stop");
    rdchk(pfcu_pkg::OFF_POWER, 32'h0000_0023, "power");
    wakeup;
    chk_word(32'(sysclk_run), 32'h0000_0001, "run");
    rdchk(pfcu_pkg::OFF_STATUS, 32'h0000_0007, "status");
    $display("t_power done");
  endtask : t_power

  // Reset is held twelve cycles, then the scenarios run in order.
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_jaddr;
    t_call;
    t_irq;
    t_power;
    final_report;
  end
endmodule : tb_top

bind pfcu_top pfcu_monitor #(.PC_W(PC_W), .NSRC(NSRC)) u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .instr_valid(instr_valid), .instr_word(instr_word), .pc(pc), .sysclk_run(sysclk_run), .halt_mode(halt_mode),
  .stop_mode(stop_mode));
`default_nettype wire
